// >>> hdl/sgc_global_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "sgc_params.svh"

// What this block does
// - run bit one runs switching, resets one
// - bit seven selects alternative back-off algorithm
// - soft reset bit holds machines, datapath reset
// - soft reset drops reception, configuration kept
// - writing purge bit starts learned table purge
// - purge bit clears itself when purge done
// - purge removes only learning-disabled ports' entries
module sgc_global_regs
#(
   parameter int         DEPTH        = `SGC_TABLE_DEPTH,
   parameter int         NPORTS       = `SGC_NUM_PORTS,
   parameter logic [7:0] PRODUCT_LINE = `SGC_ID_PRODUCT_LINE,
   parameter logic [3:0] PART         = `SGC_ID_PART,
   parameter logic [2:0] STEP         = `SGC_ID_STEP,
   parameter int         IW           = $clog2(DEPTH),
   parameter int         PW           = $clog2(NPORTS)
)
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata,
   output logic                   switch_run,
   output logic                   rx_enable,
   output logic                   backoff_alt,
   output logic                   datapath_hold,
   output logic                   purge_busy,
   input  wire logic [NPORTS-1:0] port_learn_off,
   input  wire logic              tbl_entry_valid,
   input  wire logic [PW-1:0]     tbl_entry_port,
   output logic      [IW-1:0]     tbl_index,
   output logic                   tbl_clear,
   output logic      [IW-1:0]     tbl_clear_index
);

   logic run;
   logic alt_backoff;
   logic soft_reset;
   logic purge_req;

   sgc_purge_if pif ();

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire logic sel_id    = (reg_addr == `SGC_OFS_PRODUCT_LINE);
   wire logic sel_part  = (reg_addr == `SGC_OFS_PART_RUN);
   wire logic sel_gctrl = (reg_addr == `SGC_OFS_GCTRL_FIRST);
   wire logic wr_part   = reg_wr && sel_part;
   wire logic wr_gctrl  = reg_wr && sel_gctrl;

   // identification bits are constants, so writes have nothing to land in
   wire logic [7:0] rd_id    = PRODUCT_LINE;
   wire logic [7:0] rd_part  = {PART, STEP, run};
   wire logic [7:0] rd_gctrl = {alt_backoff, soft_reset, purge_req, 5'h00};
   wire logic [7:0] next_rdata = sel_id    ? rd_id
                               : sel_part  ? rd_part
                               : sel_gctrl ? rd_gctrl
                               : 8'h00;

   // ---------------------------------------------------------------
   // next values
   // ---------------------------------------------------------------
   wire logic next_run        = wr_part ? reg_wdata[`SGC_BIT_RUN] : run;
   wire logic next_alt        = wr_gctrl ? reg_wdata[`SGC_BIT_ALT_BACKOFF] : alt_backoff;
   wire logic next_soft_reset = wr_gctrl ? reg_wdata[`SGC_BIT_SOFT_RESET] : soft_reset;
   wire logic purge_write     = wr_gctrl && reg_wdata[`SGC_BIT_PURGE];
   // a new write wins over the self clear so a late request is not lost
   wire logic next_purge      = purge_write ? 1'b1 : (pif.done ? 1'b0 : purge_req);

   assign pif.start = purge_req && !pif.busy && !pif.done;
   assign pif.hold  = soft_reset;

   // ---------------------------------------------------------------
   // configuration, only chip reset touches it
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         run         <= `SGC_RST_RUN;
         alt_backoff <= `SGC_RST_ALT_BACKOFF;
         soft_reset  <= `SGC_RST_SOFT_RESET;
         purge_req   <= `SGC_RST_PURGE;
      end
      else
      begin
         run         <= next_run;
         alt_backoff <= next_alt;
         soft_reset  <= next_soft_reset;
         purge_req   <= next_purge;
      end
   end

   // ---------------------------------------------------------------
   // output flops
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         reg_rdata     <= 8'h00;
         switch_run    <= `SGC_RST_RUN;
         rx_enable     <= `SGC_RST_RUN;
         backoff_alt   <= `SGC_RST_ALT_BACKOFF;
         datapath_hold <= `SGC_RST_SOFT_RESET;
         purge_busy    <= 1'b0;
      end
      else
      begin
         if (reg_rd)
            reg_rdata <= next_rdata;
         switch_run    <= run;
         rx_enable     <= run && !soft_reset;
         backoff_alt   <= alt_backoff;
         datapath_hold <= soft_reset;
         purge_busy    <= purge_req;
      end
   end

   // the host must turn off learning everywhere for a full purge
   sgc_purge_walker
   #(
      .DEPTH  (DEPTH),
      .NPORTS (NPORTS)
   )
   u_walker
   (
      .mclk            (mclk),
      .rstn            (rstn),
      .pif             (pif),
      .port_learn_off  (port_learn_off),
      .tbl_entry_valid (tbl_entry_valid),
      .tbl_entry_port  (tbl_entry_port),
      .tbl_index       (tbl_index),
      .tbl_clear       (tbl_clear),
      .tbl_clear_index (tbl_clear_index)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   run_follow_a: assert property (wr_part |=> ##1 (switch_run == $past(reg_wdata[`SGC_BIT_RUN], 2)))
      else $error("run output does not follow written bit");
   backoff_sel_a: assert property
      (wr_gctrl |=> ##1 (backoff_alt == $past(reg_wdata[`SGC_BIT_ALT_BACKOFF], 2)))
      else $error("back-off select does not follow written bit");
   hold_follow_a: assert property (wr_gctrl && reg_wdata[`SGC_BIT_SOFT_RESET] |=> ##1 datapath_hold)
      else $error("soft reset not applied");
   rx_drop_a: assert property (datapath_hold |-> !rx_enable)
      else $error("reception still enabled in soft reset");
   cfg_keep_a: assert property (soft_reset && !reg_wr |=> $stable(run) && $stable(alt_backoff))
      else $error("configuration changed in soft reset");
   purge_set_a: assert property (purge_write |=> purge_req)
      else $error("purge write not registered");
   purge_self_clear_a: assert property (pif.done && !purge_write |=> !purge_req)
      else $error("purge bit not self cleared");
   id_fixed_a: assert property (reg_rd && sel_id |=> reg_rdata == PRODUCT_LINE)
      else $error("identification read wrong");

   // ---------------------------------------------------------------
   // read path checks
   // ---------------------------------------------------------------
   part_fixed_a: assert property (reg_rd && sel_part |=> reg_rdata[7:`SGC_STEP_LSB] == {PART, STEP})
      else $error("part and step codes read wrong");
   unmapped_zero_a: assert property (reg_rd && !sel_id && !sel_part && !sel_gctrl |=> reg_rdata == 8'h00)
      else $error("unmapped address read not zero");
   purge_read_a: assert property (reg_rd && sel_gctrl |=> reg_rdata[`SGC_BIT_PURGE] == $past(purge_req))
      else $error("purge bit read back wrong");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");

   // ---------------------------------------------------------------
   // level and hold checks
   // ---------------------------------------------------------------
   halt_follow_a: assert property (!run |=> !switch_run)
      else $error("switching not halted with run bit clear");
   rx_enable_a: assert property (run && !soft_reset |=> rx_enable)
      else $error("reception not enabled");
   hold_release_a: assert property (wr_gctrl && !reg_wdata[`SGC_BIT_SOFT_RESET] |=> ##1 !datapath_hold)
      else $error("soft reset not released");
   run_hold_a: assert property (!wr_part |=> $stable(run))
      else $error("run bit changed without a write");
   alt_hold_a: assert property (!wr_gctrl |=> $stable(alt_backoff))
      else $error("back-off select changed without a write");

   // ---------------------------------------------------------------
   // purge handshake checks
   // ---------------------------------------------------------------
   walker_held_a: assert property (soft_reset |=> !pif.busy)
      else $error("purge walker not held in soft reset");
   busy_follow_a: assert property (purge_req |=> purge_busy)
      else $error("purge busy not raised");
   busy_drop_a: assert property (!purge_req |=> !purge_busy)
      else $error("purge busy not dropped");
   start_once_a: assert property (pif.start && !soft_reset |=> !pif.start)
      else $error("walk start held too long");
   done_pulse_a: assert property (pif.done |=> !pif.done)
      else $error("done longer than one cycle");
   purge_keep_a: assert property (soft_reset && purge_req && !pif.done |=> purge_req)
      else $error("purge request lost in soft reset");

   // ---------------------------------------------------------------
   // coverage
   // ---------------------------------------------------------------
   purge_run_c: cover property (purge_write ##[1:8] pif.busy);
   soft_reset_c: cover property (wr_gctrl && reg_wdata[`SGC_BIT_SOFT_RESET]);
   halt_c: cover property (wr_part && !reg_wdata[`SGC_BIT_RUN]);

endmodule

`default_nettype wire

// >>> hdl/sgc_params.svh
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define SGC_OFS_PRODUCT_LINE 8'h00
`define SGC_OFS_PART_RUN     8'h01
`define SGC_OFS_GCTRL_FIRST  8'h02

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SGC_BIT_RUN          0
`define SGC_BIT_ALT_BACKOFF  7
`define SGC_BIT_SOFT_RESET   6
`define SGC_BIT_PURGE        5
`define SGC_STEP_LSB         1
`define SGC_PART_LSB         4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SGC_RST_RUN          1'h1
`define SGC_RST_ALT_BACKOFF  1'h0
`define SGC_RST_SOFT_RESET   1'h0
`define SGC_RST_PURGE        1'h0

// ---------------------------------------------------------------
// identity defaults, values arbitrary
// ---------------------------------------------------------------
`define SGC_ID_PRODUCT_LINE  8'h5a
`define SGC_ID_PART          4'h3
`define SGC_ID_STEP          3'h1

// ---------------------------------------------------------------
// table defaults
// ---------------------------------------------------------------
`define SGC_TABLE_DEPTH      1024
`define SGC_NUM_PORTS        4

`endif

// >>> hdl/sgc_pkg.sv
`default_nettype none

package sgc_pkg;

   typedef enum logic [1:0]
   {
      SGC_IDLE   = 2'b00,
      SGC_ISSUE  = 2'b01,
      SGC_CHECK  = 2'b10,
      SGC_FINISH = 2'b11
   } sgc_purge_state_type;

endpackage

`default_nettype wire

// >>> hdl/sgc_purge_if.sv
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// control link between register bank and purge walker
// ---------------------------------------------------------------
interface sgc_purge_if;
   logic start;
   logic hold;
   logic busy;
   logic done;

   modport ctl
   (
      output start,
      output hold,
      input  busy,
      input  done
   );

   modport eng
   (
      input  start,
      input  hold,
      output busy,
      output done
   );
endinterface

`default_nettype wire

// >>> hdl/sgc_purge_walker.sv
`timescale 1ns/100ps
`default_nettype none
`include "sgc_params.svh"

module sgc_purge_walker
#(
   parameter int DEPTH  = `SGC_TABLE_DEPTH,
   parameter int NPORTS = `SGC_NUM_PORTS,
   parameter int IW     = $clog2(DEPTH),
   parameter int PW     = $clog2(NPORTS)
)
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   sgc_purge_if.eng               pif,
   input  wire logic [NPORTS-1:0] port_learn_off,
   input  wire logic              tbl_entry_valid,
   input  wire logic [PW-1:0]     tbl_entry_port,
   output logic      [IW-1:0]     tbl_index,
   output logic                   tbl_clear,
   output logic      [IW-1:0]     tbl_clear_index
);

   sgc_pkg::sgc_purge_state_type state;
   sgc_pkg::sgc_purge_state_type next_state;

   wire logic           wrst      = !rstn || pif.hold;
   wire logic           last      = (tbl_index == IW'(DEPTH - 1));
   wire logic           port_off  = port_learn_off[tbl_entry_port];
   // learning ports keep their entries
   wire logic           match     = (state == sgc_pkg::SGC_CHECK) && tbl_entry_valid && port_off;
   wire logic [IW-1:0]  next_index = (state == sgc_pkg::SGC_IDLE) ? '0
                                   : (state == sgc_pkg::SGC_CHECK) ? tbl_index + IW'(1) : tbl_index;

   always_comb
   begin
      next_state = state;
      unique case (state)
         sgc_pkg::SGC_IDLE:   if (pif.start) next_state = sgc_pkg::SGC_ISSUE;
         sgc_pkg::SGC_ISSUE:  next_state = sgc_pkg::SGC_CHECK;
         sgc_pkg::SGC_CHECK:  next_state = last ? sgc_pkg::SGC_FINISH : sgc_pkg::SGC_ISSUE;
         sgc_pkg::SGC_FINISH: next_state = sgc_pkg::SGC_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // walker registers, soft reset holds them idle
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (wrst)
      begin
         state           <= sgc_pkg::SGC_IDLE;
         tbl_index       <= '0;
         tbl_clear       <= 1'b0;
         tbl_clear_index <= '0;
         pif.done        <= 1'b0;
         pif.busy        <= 1'b0;
      end
      else
      begin
         state           <= next_state;
         tbl_index       <= next_index;
         tbl_clear       <= match;
         tbl_clear_index <= tbl_index;
         pif.done        <= (state == sgc_pkg::SGC_FINISH);
         pif.busy        <= (next_state != sgc_pkg::SGC_IDLE);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (wrst);

   clear_learn_off_a: assert property (tbl_clear |-> $past(tbl_entry_valid) && $past(port_off))
      else $error("entry cleared for a learning port");
   keep_learning_a: assert property ((state == sgc_pkg::SGC_CHECK) && !port_off |=> !tbl_clear)
      else $error("learning port entry was cleared");
   walk_finish_a: assert property ((state == sgc_pkg::SGC_CHECK) && last |=> ##1 pif.done)
      else $error("walk end did not signal done");

   walk_start_c: cover property (pif.start && (state == sgc_pkg::SGC_IDLE));
   entry_clear_c: cover property (tbl_clear);

endmodule

`default_nettype wire

// >>> tb/sgc_testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "sgc_params.svh"

module testbench;
   localparam int         DEPTH = 8;
   localparam logic [7:0] ID1   = {`SGC_ID_PART, `SGC_ID_STEP, 1'b0};
   logic              mclk;
   logic              rstn;
   logic [7:0]        reg_addr;
   logic              reg_wr;
   logic              reg_rd;
   logic [7:0]        reg_wdata;
   logic [7:0]        reg_rdata;
   logic              switch_run;
   logic              rx_enable;
   logic              backoff_alt;
   logic              datapath_hold;
   logic              purge_busy;
   logic [3:0]        port_learn_off;
   logic              tbl_entry_valid;
   logic [1:0]        tbl_entry_port;
   logic [2:0]        tbl_index;
   logic              tbl_clear;
   logic [2:0]        tbl_clear_index;
   logic [DEPTH-1:0]  ent_valid;
   logic [1:0]        ent_port [DEPTH];
   logic [DEPTH-1:0]  cleared;
   logic [7:0]        d;
   logic [27:0]       rows [8];
   int                n_mismatch;
   int                compares;

   sgc_global_regs #(.DEPTH(DEPTH)) DUT
   (
      .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .switch_run(switch_run), .rx_enable(rx_enable),
      .backoff_alt(backoff_alt), .datapath_hold(datapath_hold), .purge_busy(purge_busy),
      .port_learn_off(port_learn_off), .tbl_entry_valid(tbl_entry_valid), .tbl_entry_port(tbl_entry_port),
      .tbl_index(tbl_index), .tbl_clear(tbl_clear), .tbl_clear_index(tbl_clear_index)
   );

   // ---------------------------------------------------------------
   // clock and learned table stand-in
   // ---------------------------------------------------------------
   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   // one cycle table latency, answered on the falling edge
   always @(negedge mclk)
   begin
      tbl_entry_valid <= ent_valid[tbl_index];
      tbl_entry_port  <= ent_port[tbl_index];
   end

   always @(posedge mclk)
      if (tbl_clear === 1'b1)
         cleared[tbl_clear_index] <= 1'b1;

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task tally_and_finish;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk);
      reg_addr  = a;
      reg_wdata = v;
      reg_wr    = 1'b1;
      @(negedge mclk);
      reg_wr    = 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge mclk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge mclk);
      reg_rd   = 1'b0;
      v        = reg_rdata;
   endtask

   // hold_mid drops a soft reset into the walk, then lifts it again
   task do_purge(input logic [3:0] lo, input bit hold_mid);
      logic [DEPTH-1:0] exp;
      int i;
      port_learn_off = lo;
      cleared        = '0;
      wr(8'h02, 8'h20);
      repeat (2) @(negedge mclk);
      chk("purge_busy", 8'h01, {7'h0, purge_busy});
      if (hold_mid)
      begin
         wr(8'h02, 8'h60);
         repeat (2) @(negedge mclk);
         chk("hold outs", 8'h0b, {4'h0, switch_run, rx_enable, purge_busy, datapath_hold});
         rd(8'h02, d);
         chk("gctrl in hold", 8'h60, d);
         rd(8'h01, d);
         chk("part in hold", ID1 | 8'h01, d);
         wr(8'h02, 8'h00);
      end
      for (i = 0; i < 200 && purge_busy !== 1'b0; i++)
         @(negedge mclk);
      if (purge_busy !== 1'b0)
      begin
         n_mismatch++;
         $display("mismatch purge_busy expected 0 seen %b", purge_busy);
         tally_and_finish();
      end
      rd(8'h02, d);
      chk("purge self clear", 8'h00, d);
      for (i = 0; i < DEPTH; i++)
         exp[i] = ent_valid[i] & lo[ent_port[i]];
      chk("cleared set", exp, cleared);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      port_learn_off = 4'h0;
      n_mismatch = 0;
      compares = 0;
      cleared = '0;
      ent_valid = 8'b1011_0111;
      ent_port  = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
      // addr, write data, read back, {switch_run, rx_enable, backoff_alt, datapath_hold}
      rows = '{{8'h00, 8'hff, `SGC_ID_PRODUCT_LINE, 4'hc}, {8'h01, 8'h00, ID1, 4'h0},
               {8'h01, 8'hff, ID1 | 8'h01, 4'hc}, {8'h02, 8'h80, 8'h80, 4'he},
               {8'h02, 8'h1f, 8'h00, 4'hc}, {8'h05, 8'hff, 8'h00, 4'hc},
               {8'h02, 8'h40, 8'h40, 4'h9}, {8'h02, 8'h00, 8'h00, 4'hc}};
      repeat (8) @(negedge mclk);
      chk("reset outs", 8'h0c, {4'h0, switch_run, rx_enable, backoff_alt, datapath_hold});
      chk("reset purge", 8'h00, {6'h0, purge_busy, tbl_clear});
      rstn = 1'b1;
      rd(8'h01, d);
      chk("reset part", ID1 | 8'h01, d);
      rd(8'h02, d);
      chk("reset gctrl", 8'h00, d);
      foreach (rows[k])
      begin
         wr(rows[k][27:20], rows[k][19:12]);
         rd(rows[k][27:20], d);
         chk("row read", rows[k][11:4], d);
         chk("row outs", {4'h0, rows[k][3:0]}, {4'h0, switch_run, rx_enable, backoff_alt, datapath_hold});
      end
      // the remap base location is only ever read, never written
      rd(8'hbf, d);
      chk("remap base", 8'h00, d);
      do_purge(4'b0101, 1'b0);
      do_purge(4'b1111, 1'b0);
      do_purge(4'b1111, 1'b1);
      // mid-run chip reset must bring every default back
      wr(8'h01, 8'h00);
      wr(8'h02, 8'hc0);
      rd(8'h00, d);
      chk("id before reset", `SGC_ID_PRODUCT_LINE, d);
      rstn = 1'b0;
      repeat (2) @(negedge mclk);
      chk("mid reset outs", 8'h0c, {4'h0, switch_run, rx_enable, backoff_alt, datapath_hold});
      chk("mid reset rdata", 8'h00, reg_rdata);
      chk("mid reset purge", 8'h00, {6'h0, purge_busy, tbl_clear});
      rstn = 1'b1;
      rd(8'h02, d);
      chk("mid reset gctrl", 8'h00, d);
      rd(8'h01, d);
      chk("mid reset part", ID1 | 8'h01, d);
      tally_and_finish();
   end
endmodule

`default_nettype wire
